//--- core/adcc_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Registers are 8 bits wide in the low byte of each word
package adcc_pkg;

    localparam logic [11:0] ADCC_OFF_START_CHANNEL   = 12'h000;
    localparam logic [11:0] ADCC_OFF_SOURCE_CLOCK    = 12'h004;
    localparam logic [11:0] ADCC_OFF_AMP_REFERENCE   = 12'h008;
    localparam logic [11:0] ADCC_OFF_BANDGAP         = 12'h00C;
    localparam logic [11:0] ADCC_OFF_RESULT_LOW      = 12'h010;
    localparam logic [11:0] ADCC_OFF_RESULT_HIGH     = 12'h014;

    localparam logic [7:0] ADCC_RST_REG = 8'h00;

    // Writable bit masks; unimplemented bits read zero
    localparam logic [7:0] ADCC_MASK_START_CHANNEL = 8'hBF;
    localparam logic [7:0] ADCC_MASK_SOURCE_CLOCK  = 8'hF7;
    localparam logic [7:0] ADCC_MASK_AMP_REFERENCE = 8'h9F;
    localparam logic [7:0] ADCC_MASK_BANDGAP       = 8'h01;

    localparam int ADCC_BIT_START    = 7;
    localparam int ADCC_BIT_BUSY     = 6;
    localparam int ADCC_BIT_ENABLE   = 5;
    localparam int ADCC_BIT_FORMAT   = 4;
    localparam int ADCC_BIT_AMP_EN   = 7;
    localparam int ADCC_BIT_AMP_IN   = 4;

    // Converter clock cycles per conversion (successive approximation)
    localparam logic [4:0] ADCC_CONV_CYCLES = 5'd16;

    typedef enum logic [3:0] {
        ADCC_SRC_EXTERNAL,
        ADCC_SRC_SUPPLY,
        ADCC_SRC_SUPPLY_HALF,
        ADCC_SRC_SUPPLY_QUARTER,
        ADCC_SRC_AMP,
        ADCC_SRC_AMP_HALF,
        ADCC_SRC_AMP_QUARTER,
        ADCC_SRC_GROUND
    } adcc_source_type;

    typedef enum logic [1:0] {
        ADCC_REF_SUPPLY,
        ADCC_REF_PIN,
        ADCC_REF_AMP
    } adcc_ref_type;

    typedef struct packed {
        logic            converter_on;
        logic            sample_start;
        logic            conv_clock_tick;
        adcc_source_type source;
        logic            external_connect;
        logic [15:0]     channel_onehot;
        adcc_ref_type    reference;
        logic            reference_pin_connect;
        logic            amplifier_on;
        logic            amplifier_from_bandgap;
        logic            amplifier_pin_connect;
        logic [1:0]      amplifier_gain_select;
        logic            bandgap_on;
    } adcc_analog_ctrl_type;

endpackage

//--- core/adcc_top.sv
// Purpose: Control registers and sequencing for a 12-bit SAR converter
// Assumes: APB slave on clk; analogue core returns done with a result word
// Notes:   Outputs are registered; pin functions are handed over per channel
//
// Contract
// - Start only after start bit high then low
// - Busy set on start, cleared on completion
// - Enable low powers off, results kept
// - Format bit picks result byte alignment
// - Channel codes 0-9, 12-15; 10, 11 reserved
// - Source 0000, 0100, 11xx use external channel
// - Other source codes pick supply, amplifier, ground
// - Internal source disconnects external channel input
// - Clock select divides by powers of two
// - Amplifier input pin or bandgap, pin off
// - Reference supply, pin, or amplifier output
// - Gain select codes pass to amplifier
// - Unimplemented bits read zero, writes ignored
// - Channel pin drops I/O and pull-high
// - Result bits outside format read zero
// - Completion pulses the interrupt request
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module adcc_top (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr,
    input  wire logic                          conv_done,
    input  wire logic [11:0]                   conv_result,
    output adcc_pkg::adcc_analog_ctrl_type     analog_ctrl,
    output logic [15:0]                        pin_analog_mode,
    output logic                               conv_irq_request
);

    logic        rst_meta;
    logic        rst_sync_n;
    logic [7:0]  start_channel;
    logic [7:0]  source_clock;
    logic [7:0]  amp_reference;
    logic [7:0]  bandgap_ctrl;
    logic [11:0] result;
    logic        busy;
    logic        start_was_high;
    logic [6:0]  div_count;
    logic [4:0]  conv_count;
    logic        done_meta;
    logic        done_sync;
    logic        done_prev;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Bus decode
    wire logic access_phase = psel && penable;
    // Write lands only at the completing edge, when ready is already high
    wire logic write_en     = access_phase && pready && pwrite && pstrb[0];
    wire logic hit_sc  = paddr == adcc_pkg::ADCC_OFF_START_CHANNEL;
    wire logic hit_sk  = paddr == adcc_pkg::ADCC_OFF_SOURCE_CLOCK;
    wire logic hit_ar  = paddr == adcc_pkg::ADCC_OFF_AMP_REFERENCE;
    wire logic hit_bg  = paddr == adcc_pkg::ADCC_OFF_BANDGAP;
    wire logic hit_rl  = paddr == adcc_pkg::ADCC_OFF_RESULT_LOW;
    wire logic hit_rh  = paddr == adcc_pkg::ADCC_OFF_RESULT_HIGH;
    wire logic hit_any = hit_sc || hit_sk || hit_ar || hit_bg || hit_rl || hit_rh;

    wire logic [7:0] wbyte = pwdata[7:0];

    // Control fields
    wire logic       start_bit   = start_channel[adcc_pkg::ADCC_BIT_START];
    wire logic       enable_bit  = start_channel[adcc_pkg::ADCC_BIT_ENABLE];
    wire logic       format_bit  = start_channel[adcc_pkg::ADCC_BIT_FORMAT];
    wire logic [3:0] chan_sel    = start_channel[3:0];
    wire logic [3:0] src_sel     = source_clock[7:4];
    wire logic [2:0] clk_sel     = source_clock[2:0];
    wire logic [1:0] ref_sel     = amp_reference[3:2];
    wire logic       amp_in_sel  = amp_reference[adcc_pkg::ADCC_BIT_AMP_IN];

    // Start request: falling edge of start bit after a high level
    wire logic start_fall    = start_was_high && !start_bit;
    wire logic start_trigger = start_fall && enable_bit;

    // Division tick: counter low bits all ones for the selected ratio
    wire logic [6:0] div_mask = 7'((8'h01 << clk_sel) - 8'h01);
    wire logic       div_tick = (div_count & div_mask) == div_mask;

    // Completion from internal count or from the analogue core
    wire logic count_done = busy && div_tick && conv_count == adcc_pkg::ADCC_CONV_CYCLES - 5'd1;
    wire logic core_done  = busy && done_sync && !done_prev;
    wire logic finish     = count_done || core_done;

    // Source decode
    adcc_pkg::adcc_source_type src_decoded;
    always_comb begin
        unique casez (src_sel)
            4'b0000, 4'b0100, 4'b11??: src_decoded = adcc_pkg::ADCC_SRC_EXTERNAL;
            4'b0001: src_decoded = adcc_pkg::ADCC_SRC_SUPPLY;
            4'b0010: src_decoded = adcc_pkg::ADCC_SRC_SUPPLY_HALF;
            4'b0011: src_decoded = adcc_pkg::ADCC_SRC_SUPPLY_QUARTER;
            4'b0101: src_decoded = adcc_pkg::ADCC_SRC_AMP;
            4'b0110: src_decoded = adcc_pkg::ADCC_SRC_AMP_HALF;
            4'b0111: src_decoded = adcc_pkg::ADCC_SRC_AMP_QUARTER;
            default: src_decoded = adcc_pkg::ADCC_SRC_GROUND;
        endcase
    end

    wire logic ext_selected = src_decoded == adcc_pkg::ADCC_SRC_EXTERNAL;
    wire logic chan_legal   = chan_sel != 4'hA && chan_sel != 4'hB;
    wire logic ext_connect  = ext_selected && enable_bit && chan_legal;

    wire adcc_pkg::adcc_ref_type ref_decoded =
        ref_sel[1] ? adcc_pkg::ADCC_REF_AMP :
        (ref_sel[0] ? adcc_pkg::ADCC_REF_PIN : adcc_pkg::ADCC_REF_SUPPLY);

    // Per-channel select and pin handover
    logic [15:0] chan_onehot;
    logic [15:0] pin_mode;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_chan
            assign chan_onehot[gi] = ext_connect && chan_sel == 4'(gi);
            // Pin leaves I/O and pull-high while assigned as converter input
            assign pin_mode[gi]    = enable_bit && chan_legal && chan_sel == 4'(gi);
        end
    endgenerate

    // Result layout per format, unused bits zero
    wire logic [7:0] res_low  = format_bit ? result[7:0] : {result[3:0], 4'h0};
    wire logic [7:0] res_high = format_bit ? {4'h0, result[11:8]} : result[11:4];

    wire logic [7:0] rd_byte =
        hit_sc ? {start_channel[7], busy, start_channel[5:0]} :
        hit_sk ? (source_clock & adcc_pkg::ADCC_MASK_SOURCE_CLOCK) :
        hit_ar ? (amp_reference & adcc_pkg::ADCC_MASK_AMP_REFERENCE) :
        hit_bg ? (bandgap_ctrl & adcc_pkg::ADCC_MASK_BANDGAP) :
        hit_rl ? res_low :
        hit_rh ? res_high : 8'h00;

    wire adcc_pkg::adcc_analog_ctrl_type next_analog = '{
        converter_on:           enable_bit,
        sample_start:           start_trigger,
        conv_clock_tick:        busy && div_tick,
        source:                 src_decoded,
        external_connect:       ext_connect,
        channel_onehot:         chan_onehot,
        reference:              ref_decoded,
        reference_pin_connect:  ref_decoded == adcc_pkg::ADCC_REF_PIN,
        amplifier_on:           amp_reference[adcc_pkg::ADCC_BIT_AMP_EN],
        amplifier_from_bandgap: amp_in_sel,
        amplifier_pin_connect:  !amp_in_sel,
        amplifier_gain_select:  amp_reference[1:0],
        bandgap_on:             bandgap_ctrl[0]
    };

    // Register writes; busy bit position never stored
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            start_channel <= adcc_pkg::ADCC_RST_REG;
            source_clock  <= adcc_pkg::ADCC_RST_REG;
            amp_reference <= adcc_pkg::ADCC_RST_REG;
            bandgap_ctrl  <= adcc_pkg::ADCC_RST_REG;
        end else if (write_en) begin
            if (hit_sc) start_channel <= wbyte & adcc_pkg::ADCC_MASK_START_CHANNEL;
            if (hit_sk) source_clock  <= wbyte & adcc_pkg::ADCC_MASK_SOURCE_CLOCK;
            if (hit_ar) amp_reference <= wbyte & adcc_pkg::ADCC_MASK_AMP_REFERENCE;
            if (hit_bg) bandgap_ctrl  <= wbyte & adcc_pkg::ADCC_MASK_BANDGAP;
        end
    end

    // Start edge tracking
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) start_was_high <= 1'b0;
        else             start_was_high <= start_bit;
    end

    // Busy flag and conversion sequencing
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            busy       <= 1'b0;
            conv_count <= 5'd0;
        end else if (start_trigger) begin
            busy       <= 1'b1;
            conv_count <= 5'd0;
        end else if (!enable_bit || finish) begin
            busy       <= 1'b0;
            conv_count <= 5'd0;
        end else if (busy && div_tick) begin
            conv_count <= conv_count + 5'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n)     div_count <= 7'd0;
        else if (!busy)      div_count <= 7'd0;
        else                 div_count <= div_count + 7'd1;
    end

    // Done from analogue core passes two flops
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
            done_prev <= 1'b0;
        end else begin
            done_meta <= conv_done;
            done_sync <= done_meta;
            done_prev <= done_sync;
        end
    end

    // Result capture only while enabled
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n)               result <= 12'h000;
        else if (finish && enable_bit) result <= conv_result;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) conv_irq_request <= 1'b0;
        else             conv_irq_request <= finish;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            analog_ctrl     <= '0;
            pin_analog_mode <= 16'h0000;
        end else begin
            analog_ctrl     <= next_analog;
            pin_analog_mode <= pin_mode;
        end
    end

    // APB answer: one wait state, ready on the cycle after access phase starts
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= access_phase && !pready;
            prdata  <= {24'h000000, rd_byte};
            pslverr <= access_phase && !pready && !hit_any;
        end
    end

endmodule

//--- verif/adcc_assertions.sv
// Purpose: Port checks for the converter control block
// Assumes: Sees only the top ports
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
module adcc_assertions (
    input wire logic                           clk,
    input wire logic                           rstn,
    input wire logic                           pready,
    input wire logic [31:0]                    prdata,
    input wire logic                           pslverr,
    input wire adcc_pkg::adcc_analog_ctrl_type analog_ctrl,
    input wire logic                           conv_irq_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_irq; conv_irq_request |=> !conv_irq_request; endproperty
    a_irq: assert property (p_irq) else $error("request not a pulse");
    property p_start; analog_ctrl.sample_start |=> !analog_ctrl.sample_start; endproperty
    a_start: assert property (p_start) else $error("start not a pulse");
    property p_on; analog_ctrl.sample_start |-> analog_ctrl.converter_on; endproperty
    a_on: assert property (p_on) else $error("start while off");
    property p_ext;
        analog_ctrl.source != adcc_pkg::ADCC_SRC_EXTERNAL |-> !analog_ctrl.external_connect;
    endproperty
    a_ext: assert property (p_ext) else $error("external joined to internal");
    property p_one; $onehot0(analog_ctrl.channel_onehot); endproperty
    a_one: assert property (p_one) else $error("several channels");
    property p_rsv; analog_ctrl.channel_onehot[11:10] == 2'b00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved channel");
    property p_amp; analog_ctrl.amplifier_from_bandgap |-> !analog_ctrl.amplifier_pin_connect; endproperty
    a_amp: assert property (p_amp) else $error("amplifier pin left on");
    property p_ref;
        analog_ctrl.reference != adcc_pkg::ADCC_REF_PIN |-> !analog_ctrl.reference_pin_connect;
    endproperty
    a_ref: assert property (p_ref) else $error("reference pin left on");
    c_start: cover property (analog_ctrl.sample_start);
    c_irq: cover property (conv_irq_request);
    c_err: cover property (pslverr);
endmodule

//--- verif/adcc_core_model.sv
// Purpose: Behavioural converter core facing the control block
// Assumes: mode 0 answers fast, 1 slowly, 2 never
// Notes:   Result shows an inverted pattern while converting
`timescale 1ns/1ns
module adcc_core_model (
    input  wire logic                           clk,
    input  wire logic [1:0]                     mode,
    input  wire logic [11:0]                    value,
    input  wire adcc_pkg::adcc_analog_ctrl_type analog_ctrl,
    output logic                                conv_done,
    output logic [11:0]                         conv_result
);
    int count = 0;
    initial begin
        conv_done = 1'b0;
        conv_result = 12'h5A5;
    end
    always @(posedge clk) begin
        if (analog_ctrl.sample_start) begin
            count <= (mode == 2'd0) ? 5 : (mode == 2'd1) ? 40 : 0;
            conv_done <= 1'b0;
            conv_result <= ~conv_result;
        end else if (count == 1) begin
            count <= 0;
            conv_done <= 1'b1;
            conv_result <= value;
        end else if (count > 1) begin
            count <= count - 1;
        end
    end
endmodule

//--- verif/tb_adcc_top.sv
// Purpose: Register level tests of the converter control block
// Assumes: APB master tasks, core model on the far side
// Notes:   Expected values come from the register layout
`timescale 1ns/1ns
module tb_adcc_top;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, conv_done, irq;
    logic [11:0] paddr, conv_result, value;
    logic [31:0] pwdata, prdata, rdata, perr;
    logic [15:0] pin_analog_mode;
    logic [1:0] mode;
    logic [7:0] masks [4] = '{8'hBF, 8'hF7, 8'h9F, 8'h01};
    adcc_pkg::adcc_analog_ctrl_type ac;
    int num_errors = 0, samples_checked = 0, irqs = 0, cyc = 0, last = 0, gap = 0, n0;
    adcc_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .conv_done(conv_done), .conv_result(conv_result), .analog_ctrl(ac),
        .pin_analog_mode(pin_analog_mode), .conv_irq_request(irq));
    adcc_core_model core (.clk(clk), .mode(mode), .value(value), .analog_ctrl(ac),
        .conv_done(conv_done), .conv_result(conv_result));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (ac.conv_clock_tick === 1'b1) begin
            gap <= cyc - last;
            last <= cyc;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) num_errors++;
        rdata = prdata;
        perr = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask
    task automatic convert(input logic [7:0] ctl);
        xfer(1'b1, 12'h000, {24'h0, ctl | 8'h80});
        xfer(1'b1, 12'h000, {24'h0, ctl});
    endtask
    task automatic wait_idle();
        int n = 0;
        do begin
            xfer(1'b0, 12'h000, 32'h0);
            n++;
        end while (rdata[6] !== 1'b0 && n < 1000);
        if (n == 1000) num_errors++;
    endtask
    function automatic adcc_pkg::adcc_source_type exp_src(input logic [3:0] s);
        case (s)
            4'h1: exp_src = adcc_pkg::ADCC_SRC_SUPPLY;
            4'h2: exp_src = adcc_pkg::ADCC_SRC_SUPPLY_HALF;
            4'h3: exp_src = adcc_pkg::ADCC_SRC_SUPPLY_QUARTER;
            4'h5: exp_src = adcc_pkg::ADCC_SRC_AMP;
            4'h6: exp_src = adcc_pkg::ADCC_SRC_AMP_HALF;
            4'h7: exp_src = adcc_pkg::ADCC_SRC_AMP_QUARTER;
            4'h8, 4'h9, 4'hA, 4'hB: exp_src = adcc_pkg::ADCC_SRC_GROUND;
            default: exp_src = adcc_pkg::ADCC_SRC_EXTERNAL;
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        stop_test();
    end
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, mode, value} = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) rdchk(12'(i * 4), 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 12'(i * 4), 32'hFFFFFFFF);
            rdchk(12'(i * 4), {24'h0, masks[i]});
        end
        xfer(1'b1, 12'h000, 32'h0);
        xfer(1'b0, 12'h020, 32'h0);
        check(perr | rdata, 32'h1);
        xfer(1'b1, 12'h010, 32'hFF);
        rdchk(12'h010, 32'h0);
        repeat (100) @(posedge clk); // Bandgap settling
        check({31'h0, ac.bandgap_on}, 32'h1);
        for (int r = 0; r < 4; r++) begin
            xfer(1'b1, 12'h008, 32'(8'h80 | r << 2 | r | (r & 1) << 4));
            repeat (2) @(posedge clk);
            check({31'h0, ac.amplifier_on}, 32'h1);
            check({30'h0, ac.reference}, r > 1 ? 32'h2 : 32'(r));
            check({31'h0, ac.reference_pin_connect}, 32'(r == 1));
            check({31'h0, ac.amplifier_pin_connect, ac.amplifier_from_bandgap}, 32'(r & 1 ? 1 : 2));
            check({30'h0, ac.amplifier_gain_select}, 32'(r));
        end
        xfer(1'b1, 12'h000, 32'h20);
        for (int s = 0; s < 16; s++) begin
            xfer(1'b1, 12'h004, 32'(s << 4));
            repeat (2) @(posedge clk);
            check({28'h0, ac.source}, {28'h0, exp_src(4'(s))});
            check({31'h0, ac.external_connect}, 32'(exp_src(4'(s)) == 0));
        end
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, 12'h000, 32'(8'h20 | c));
            repeat (2) @(posedge clk);
            check({16'h0, ac.channel_onehot}, (c == 10 || c == 11) ? 32'h0 : 32'h1 << c);
            check({16'h0, pin_analog_mode}, (c == 10 || c == 11) ? 32'h0 : 32'h1 << c);
        end
        value <= 12'h9C5;
        xfer(1'b1, 12'h004, 32'h3);
        for (int f = 0; f < 2; f++) begin
            mode <= f ? 2'd0 : 2'd1;
            n0 = irqs;
            convert(8'(8'h23 | f << 4));
            if (f == 0) rdchk(12'h000, 32'h63);
            wait_idle();
            check(rdata, 32'(8'h23 | f << 4));
            check(32'(irqs - n0), 32'h1);
            rdchk(12'h014, f ? 32'h9 : 32'h9C);
            rdchk(12'h010, f ? 32'hC5 : 32'h50);
        end
        value <= 12'h123;
        n0 = irqs;
        convert(8'h03);
        repeat (50) @(posedge clk);
        check(32'(irqs - n0), 32'h0);
        check({31'h0, ac.converter_on}, 32'h0);
        rdchk(12'h010, 32'h50);
        mode <= 2'd2;
        for (int k = 0; k < 8; k++) begin
            xfer(1'b1, 12'h004, 32'(k));
            convert(8'h20);
            wait_idle();
            check(32'(gap), 32'h1 << k);
        end
        stop_test();
    end
endmodule
bind adcc_top adcc_assertions u_chk (.clk(clk), .rstn(rstn), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .analog_ctrl(analog_ctrl), .conv_irq_request(conv_irq_request));
